// [general_timer_set.sv]
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
module general_timer_set
  import timer_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [DATA_W-1:0]     wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic      [DATA_W-1:0]     rdata,
  input  wire logic                  idle_mode,
  input  wire logic                  sleep_mode,
  input  wire logic [NUM_TIMERS-1:0] ext_clock_pin,
  output logic      [NUM_TIMERS-1:0] irq_flag,
  output logic                       adc1_trigger,
  output logic                       adc2_trigger,
  output logic      [1:0]            dma_request,
  output logic      [DATA_W-1:0]     time_base_low,
  output logic      [DATA_W-1:0]     time_base_high
);

  // Index 0 is the stand-alone timer; odd indices are low (even-numbered) pair
  // timers, even indices above zero are their high partners.
  logic [15:0]            ctrl_ff   [NUM_TIMERS];
  logic [15:0]            count_ff  [NUM_TIMERS];
  logic [15:0]            period_ff [NUM_TIMERS];
  logic [7:0]             ps_ff     [NUM_TIMERS];
  logic [NUM_TIMERS-1:0]  pin_s1_ff;
  logic [NUM_TIMERS-1:0]  pin_s2_ff;
  logic [NUM_TIMERS-1:0]  pin_d_ff;
  logic [NUM_TIMERS-1:0]  flags_ff;
  logic [NUM_TIMERS-1:0]  joined;
  logic [NUM_TIMERS-1:0]  raw_tick;
  logic [NUM_TIMERS-1:0]  raw_gfall;
  logic [NUM_TIMERS-1:0]  tick_eff;
  logic [NUM_TIMERS-1:0]  match16;
  logic [NUM_TIMERS-1:0]  match_eff;
  logic [NUM_TIMERS-1:0]  evt;
  logic [DATA_W-1:0]      rdata_ff;
  logic                   adc1_ff;
  logic                   adc2_ff;
  logic [1:0]             dma_ff;
  logic [3:0]             sel_timer;
  logic                   in_map;

  assign sel_timer = addr[5:2];
  assign in_map    = (sel_timer < 4'(NUM_TIMERS)) && (addr[1:0] != 2'h3);

  // Pins come from outside the clock domain; only pin_s2_ff and later are read.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_d_ff  <= '0;
    end else begin
      pin_s1_ff <= ext_clock_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_TIMERS; i++) begin : g_tmr
      logic [15:0] mask;
      logic        is_low;
      logic        is_high;
      logic        wr_ctrl;
      logic        wr_count;
      logic        wr_period;
      logic        async_ok;
      logic        active;
      logic        in_pulse;
      logic        gate_fall;
      logic [7:0]  ps_term;

      assign is_low    = (i % 2 == 1);
      assign is_high   = (i != 0) && (i % 2 == 0);
      assign mask      = (i == 0) ? MASK_SOLO : (is_low ? MASK_LOW : MASK_HIGH);
      assign wr_ctrl   = wr && (sel_timer == 4'(i)) && (addr[1:0] == KIND_CTRL);
      assign wr_count  = wr && (sel_timer == 4'(i)) && (addr[1:0] == KIND_COUNT);
      assign wr_period = wr && (sel_timer == 4'(i)) && (addr[1:0] == KIND_PERIOD);

      if (i == 0) begin : g_solo
        assign joined[i] = 1'b0;
      end else if (i % 2 == 1) begin : g_low
        assign joined[i] = ctrl_ff[i][JOIN_BIT];
      end else begin : g_high
        assign joined[i] = ctrl_ff[i-1][JOIN_BIT];
      end

      // Only the stand-alone timer has an asynchronous path; the pair timers have
      // no sync bit, so they always count synchronously.
      assign async_ok = (i == 0) && ctrl_ff[i][CS_BIT] && !ctrl_ff[i][SYNC_BIT];

      // The synchronous path stops with the system clock in sleep.
      assign active = ctrl_ff[i][RUN_BIT]
                      && !(ctrl_ff[i][IDLE_BIT] && idle_mode)
                      && (!sleep_mode || async_ok)
                      && !(is_high && joined[i]);

      always_comb begin
        if (ctrl_ff[i][CS_BIT]) begin
          in_pulse = pin_s2_ff[i] && !pin_d_ff[i];
        end else if (ctrl_ff[i][GATE_BIT]) begin
          in_pulse = pin_s2_ff[i];
        end else begin
          in_pulse = 1'b1;
        end
      end

      assign gate_fall = active && !ctrl_ff[i][CS_BIT] && ctrl_ff[i][GATE_BIT]
                         && pin_d_ff[i] && !pin_s2_ff[i];

      always_comb begin
        case (ctrl_ff[i][PS_HI:PS_LO])
          2'h0:    ps_term = PS_DIV1;
          2'h1:    ps_term = PS_DIV8;
          2'h2:    ps_term = PS_DIV64;
          default: ps_term = PS_DIV256;
        endcase
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          ps_ff[i] <= 8'h00;
        end else if (!active || wr_count) begin
          ps_ff[i] <= 8'h00;
        end else if (in_pulse) begin
          ps_ff[i] <= (ps_ff[i] == ps_term) ? 8'h00 : ps_ff[i] + 8'h01;
        end
      end

      assign raw_tick[i]  = active && in_pulse && (ps_ff[i] == ps_term);
      assign raw_gfall[i] = gate_fall;
      assign match16[i]   = (count_ff[i] == period_ff[i]);

      // The high half follows the low timer's clock, gate and controls.
      if (i != 0 && i % 2 == 0) begin : g_hi_eff
        assign tick_eff[i]  = joined[i] ? raw_tick[i-1] : raw_tick[i];
        assign match_eff[i] = joined[i] ? (match16[i-1] && match16[i]) : match16[i];
        assign evt[i]       = (tick_eff[i] && match_eff[i])
                              || (joined[i] ? raw_gfall[i-1] : raw_gfall[i]);
      end else if (i % 2 == 1) begin : g_lo_eff
        assign tick_eff[i]  = raw_tick[i];
        assign match_eff[i] = joined[i] ? (match16[i] && match16[i+1]) : match16[i];
        assign evt[i]       = !joined[i] && ((tick_eff[i] && match_eff[i]) || raw_gfall[i]);
      end else begin : g_solo_eff
        assign tick_eff[i]  = raw_tick[i];
        assign match_eff[i] = match16[i];
        assign evt[i]       = (tick_eff[i] && match_eff[i]) || raw_gfall[i];
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          ctrl_ff[i] <= CTRL_RESET;
        end else if (wr_ctrl) begin
          ctrl_ff[i] <= wdata & mask;
        end
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          period_ff[i] <= PERIOD_RESET;
        end else if (wr_period) begin
          period_ff[i] <= wdata;
        end
      end

      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          count_ff[i] <= COUNT_RESET;
        end else if (wr_count) begin
          count_ff[i] <= wdata;
        end else if (tick_eff[i]) begin
          if (match_eff[i]) begin
            count_ff[i] <= COUNT_RESET;
          end else if (i != 0 && i % 2 == 0 && joined[i]) begin
            if (count_ff[(i == 0) ? 0 : i-1] == COUNT_MAX) begin
              count_ff[i] <= count_ff[i] + 16'h0001;
            end
          end else begin
            count_ff[i] <= count_ff[i] + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // A flag event in the same cycle as a write-one-to-clear keeps the flag set.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flags_ff <= '0;
    end else if (wr && addr == FLAG_ADDR) begin
      flags_ff <= (flags_ff & ~wdata[NUM_TIMERS-1:0]) | evt;
    end else begin
      flags_ff <= flags_ff | evt;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      adc1_ff <= 1'b0;
      adc2_ff <= 1'b0;
      dma_ff  <= 2'b00;
    end else begin
      adc1_ff <= evt[2];
      adc2_ff <= evt[4];
      dma_ff  <= {evt[2], evt[1]};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= '0;
    end else if (rd) begin
      if (addr == FLAG_ADDR) begin
        rdata_ff <= {{(DATA_W-NUM_TIMERS){1'b0}}, flags_ff};
      end else if (!in_map) begin
        rdata_ff <= '0;
      end else begin
        case (addr[1:0])
          KIND_CTRL:   rdata_ff <= ctrl_ff[sel_timer];
          KIND_COUNT:  rdata_ff <= count_ff[sel_timer];
          KIND_PERIOD: rdata_ff <= period_ff[sel_timer];
          default:     rdata_ff <= '0;
        endcase
      end
    end else begin
      rdata_ff <= '0;
    end
  end

  assign rdata          = rdata_ff;
  assign irq_flag       = flags_ff;
  assign adc1_trigger   = adc1_ff;
  assign adc2_trigger   = adc2_ff;
  assign dma_request    = dma_ff;
  assign time_base_low  = count_ff[1];
  assign time_base_high = count_ff[2];

  logic wr_any_cnt;
  assign wr_any_cnt = wr && (addr[1:0] == KIND_COUNT);

  a_stop_holds: assert property (@(posedge mclk) disable iff (!rstn)
    !ctrl_ff[0][RUN_BIT] && !wr_any_cnt |=> $stable(count_ff[0]))
    else $error("Stopped stand-alone timer changed its count.");

  a_idle_halt: assert property (@(posedge mclk) disable iff (!rstn)
    idle_mode && ctrl_ff[0][IDLE_BIT] |-> !tick_eff[0] && !evt[0])
    else $error("Timer ran in idle with idle-halt set.");

  a_gate_level: assert property (@(posedge mclk) disable iff (!rstn)
    tick_eff[0] && !ctrl_ff[0][CS_BIT] && ctrl_ff[0][GATE_BIT] |-> pin_s2_ff[0])
    else $error("Gated timer ticked with gate low.");

  a_prescale_eight: assert property (@(posedge mclk) disable iff (!rstn)
    tick_eff[0] && ctrl_ff[0][PS_HI:PS_LO] == 2'h1 && !wr |=> !tick_eff[0] [*7])
    else $error("Divide-by-8 prescaler ticked too early.");

  a_match_clear: assert property (@(posedge mclk) disable iff (!rstn)
    tick_eff[0] && match_eff[0] && !wr |=> count_ff[0] == COUNT_RESET && flags_ff[0])
    else $error("Period match did not clear count and set flag.");

  a_join_carry: assert property (@(posedge mclk) disable iff (!rstn)
    joined[2] && tick_eff[1] && !match_eff[1] && count_ff[1] == COUNT_MAX && !wr
    |=> count_ff[2] == $past(count_ff[2]) + 16'h0001 && count_ff[1] == COUNT_RESET)
    else $error("Low word wrap did not carry into high word.");

  a_join_low_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    joined[1] |-> !evt[1])
    else $error("Joined pair raised the low timer flag.");

  a_join_match: assert property (@(posedge mclk) disable iff (!rstn)
    joined[2] && tick_eff[2] && evt[2] |-> {count_ff[2], count_ff[1]} == {period_ff[2], period_ff[1]})
    else $error("Joined pair matched without full 32-bit equality.");

  a_dma_source: assert property (@(posedge mclk) disable iff (!rstn)
    evt[1] |=> dma_request[0])
    else $error("Pair timer event gave no DMA request.");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
    rd && addr == 6'h00 |=> (rdata & ~MASK_SOLO) == 16'h0000)
    else $error("Unimplemented control bits read nonzero.");

  a_async_sleep: assert property (@(posedge mclk) disable iff (!rstn)
    sleep_mode && !(ctrl_ff[0][CS_BIT] && !ctrl_ff[0][SYNC_BIT]) |-> !tick_eff[0])
    else $error("Synchronous stand-alone timer ticked in sleep.");

  a_pair_sleep: assert property (@(posedge mclk) disable iff (!rstn)
    sleep_mode |-> tick_eff[NUM_TIMERS-1:1] == '0)
    else $error("Pair timer ticked in sleep.");

  a_ext_no_gate: assert property (@(posedge mclk) disable iff (!rstn)
    ctrl_ff[0][CS_BIT] |-> !raw_gfall[0])
    else $error("External clock mode reacted to the gate.");

  a_ext_edge_tick: assert property (@(posedge mclk) disable iff (!rstn)
    tick_eff[0] && ctrl_ff[0][CS_BIT] |-> pin_s2_ff[0] && !pin_d_ff[0])
    else $error("External clock ticked without a rising edge.");

  a_high_follows_low: assert property (@(posedge mclk) disable iff (!rstn)
    joined[2] && !ctrl_ff[1][RUN_BIT] |-> !tick_eff[2])
    else $error("Joined high half ticked while the low timer was stopped.");

  a_join_period: assert property (@(posedge mclk) disable iff (!rstn)
    joined[2] && tick_eff[2] && count_ff[2] == period_ff[2] && count_ff[1] == period_ff[1] |-> evt[2])
    else $error("Joined pair missed its 32-bit period match.");

  a_join_half_match: assert property (@(posedge mclk) disable iff (!rstn)
    joined[2] && count_ff[1] == period_ff[1] && count_ff[2] != period_ff[2] && !raw_gfall[1] |-> !evt[2])
    else $error("Joined pair matched on the low word alone.");

  a_adc1_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    evt[2] |=> adc1_trigger)
    else $error("First pair event gave no converter trigger.");

  a_adc2_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    evt[4] |=> adc2_trigger)
    else $error("Second pair event gave no converter trigger.");

  a_adc1_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    !evt[2] |=> !adc1_trigger)
    else $error("Converter trigger without a pair event.");

  a_dma_high: assert property (@(posedge mclk) disable iff (!rstn)
    evt[2] |=> dma_request[1])
    else $error("High pair timer event gave no DMA request.");

  a_dma_quiet: assert property (@(posedge mclk) disable iff (!rstn)
    !evt[1] && !evt[2] |=> dma_request == 2'b00)
    else $error("DMA request without a first pair event.");

  a_flag_sticky: assert property (@(posedge mclk) disable iff (!rstn)
    flags_ff[0] && !(wr && addr == FLAG_ADDR) |=> flags_ff[0])
    else $error("Interrupt flag dropped without a clear.");

  a_count_step: assert property (@(posedge mclk) disable iff (!rstn)
    tick_eff[0] && !match_eff[0] && !wr |=> count_ff[0] == $past(count_ff[0]) + 16'h0001)
    else $error("Count did not step by one on a tick.");

  a_idle_pair: assert property (@(posedge mclk) disable iff (!rstn)
    idle_mode && ctrl_ff[1][IDLE_BIT] |-> !tick_eff[1])
    else $error("Pair timer ran in idle with idle-halt set.");

  a_gate_fall_flag: assert property (@(posedge mclk) disable iff (!rstn)
    raw_gfall[0] |=> flags_ff[0])
    else $error("Gate falling edge did not set the flag.");

endmodule // general_timer_set

// [timer_pkg.sv]
package timer_pkg;

  localparam int          NUM_TIMERS = 9;
  localparam int          ADDR_W     = 6;
  localparam int          DATA_W     = 16;

  // Register map: timer index in addr[5:2], register kind in addr[1:0].
  localparam logic [1:0]  KIND_CTRL   = 2'h0;
  localparam logic [1:0]  KIND_COUNT  = 2'h1;
  localparam logic [1:0]  KIND_PERIOD = 2'h2;
  localparam logic [5:0]  FLAG_ADDR   = 6'h24;

  // Control register field positions.
  localparam int          RUN_BIT   = 15;
  localparam int          IDLE_BIT  = 13;
  localparam int          GATE_BIT  = 6;
  localparam int          PS_HI     = 5;
  localparam int          PS_LO     = 4;
  localparam int          JOIN_BIT  = 3;
  localparam int          SYNC_BIT  = 2;
  localparam int          CS_BIT    = 1;

  // Implemented bits of each control register flavour.
  localparam logic [15:0] MASK_SOLO = 16'hA076;
  localparam logic [15:0] MASK_LOW  = 16'hA07A;
  localparam logic [15:0] MASK_HIGH = 16'hA072;

  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;

  // Prescaler terminal counts for divide by 1, 8, 64 and 256.
  localparam logic [7:0]  PS_DIV1   = 8'h00;
  localparam logic [7:0]  PS_DIV8   = 8'h07;
  localparam logic [7:0]  PS_DIV64  = 8'h3F;
  localparam logic [7:0]  PS_DIV256 = 8'hFF;

endpackage : timer_pkg

// [test_general_timer_set.sv]
`timescale 1ns/1ps
module test_general_timer_set;
  import timer_pkg::*;

  logic                  mclk;
  logic                  rstn;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     wdata;
  logic                  wr;
  logic                  rd;
  logic [DATA_W-1:0]     rdata;
  logic                  idle_mode;
  logic                  sleep_mode;
  logic [NUM_TIMERS-1:0] ext_clock_pin;
  logic [NUM_TIMERS-1:0] irq_flag;
  logic                  adc1_trigger;
  logic                  adc2_trigger;
  logic [1:0]            dma_request;
  logic [DATA_W-1:0]     time_base_low;
  logic [DATA_W-1:0]     time_base_high;
  int                    failures;
  int                    samples_checked;
  int                    adc1_seen;
  int                    adc2_seen;
  int                    dma_seen;
  logic [15:0]           v;
  logic [15:0]           w;

  general_timer_set dut (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .idle_mode(idle_mode), .sleep_mode(sleep_mode), .ext_clock_pin(ext_clock_pin), .irq_flag(irq_flag),
    .adc1_trigger(adc1_trigger), .adc2_trigger(adc2_trigger), .dma_request(dma_request),
    .time_base_low(time_base_low), .time_base_high(time_base_high)
  );

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  // Trigger pulses last one cycle, so they are tallied at every edge rather than polled.
  always @(posedge mclk) begin
    if (adc1_trigger === 1'b1) adc1_seen++;
    if (adc2_trigger === 1'b1) adc2_seen++;
    if (dma_request !== 2'h0) dma_seen++;
  end

  function automatic logic [5:0] ra(input logic [3:0] idx, input logic [1:0] kind);
    return {idx, kind};
  endfunction

  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_range(input string name, input logic [15:0] lo, input logic [15:0] hi,
                             input logic [15:0] got);
    samples_checked++;
    if ((got < lo) || (got > hi) || ($isunknown(got))) begin
      failures++;
      $display("wrong value %s expected %h..%h seen %h", name, lo, hi, got);
    end
  endtask

  task automatic pin_pulses(input int idx, input int n);
    repeat (n) begin
      @(posedge mclk);
      ext_clock_pin[idx] <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clock_pin[idx] <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The longest stretch is the divide-by-256 run; twenty thousand cycles leaves ample slack.
  initial begin
    #160000;
    failures++;
    tally_and_finish();
  end

  initial begin
    rstn = 1'b0;
    addr = 6'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    idle_mode = 1'b0;
    sleep_mode = 1'b0;
    ext_clock_pin = '0;
    failures = 0;
    samples_checked = 0;
    adc1_seen = 0;
    adc2_seen = 0;
    dma_seen = 0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd_reg(ra(4'h1, KIND_CTRL), v);   check("ctrl reset", CTRL_RESET, v);
    rd_reg(ra(4'h1, KIND_COUNT), v);  check("count reset", COUNT_RESET, v);
    rd_reg(ra(4'h1, KIND_PERIOD), v); check("period reset", PERIOD_RESET, v);
    wr_reg(ra(4'h0, KIND_CTRL), 16'hFFFF);
    rd_reg(ra(4'h0, KIND_CTRL), v);   check("solo ctrl mask", 16'hA076, v);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h7FFF);
    rd_reg(ra(4'h1, KIND_CTRL), v);   check("low ctrl mask", 16'h207A, v);
    wr_reg(ra(4'h2, KIND_CTRL), 16'h7FFF);
    rd_reg(ra(4'h2, KIND_CTRL), v);   check("high ctrl mask", 16'h2072, v);
    wr_reg(6'h03, 16'h1234);
    rd_reg(6'h03, v);                 check("unmapped read", 16'h0000, v);
    for (int i = 0; i < 3; i++) wr_reg(ra(i[3:0], KIND_CTRL), 16'h0000);
    // Each prescale code runs ten prescaled ticks' worth of cycles, then stops and is read.
    for (int code = 0; code < 4; code++) begin
      wr_reg(ra(4'h0, KIND_COUNT), 16'h0000);
      wr_reg(ra(4'h0, KIND_CTRL), 16'h8000 | (16'(code) << 4));
      repeat ((10 << (3 * code - (code == 3 ? 1 : 0))) - 2) @(posedge mclk);
      wr_reg(ra(4'h0, KIND_CTRL), 16'h0000);
      rd_reg(ra(4'h0, KIND_COUNT), v); check_range("prescaled count", 16'h0009, 16'h000B, v);
      repeat (10) @(posedge mclk);
      rd_reg(ra(4'h0, KIND_COUNT), w); check("stopped count", v, w);
    end
    wr_reg(ra(4'h0, KIND_COUNT), 16'h0000);
    wr_reg(ra(4'h0, KIND_PERIOD), 16'h0005);
    wr_reg(FLAG_ADDR, 16'h01FF);
    wr_reg(ra(4'h0, KIND_CTRL), 16'h8000);
    repeat (30) @(posedge mclk);
    wr_reg(ra(4'h0, KIND_CTRL), 16'h0000);
    check("solo match flag", 16'h0001, {7'h00, irq_flag} & 16'h0001);
    rd_reg(ra(4'h0, KIND_COUNT), v); check_range("count wraps at period", 16'h0000, 16'h0005, v);
    wr_reg(FLAG_ADDR, 16'h0001);
    @(posedge mclk); #1;
    check("flag cleared", 16'h0000, {7'h00, irq_flag} & 16'h0001);
    wr_reg(ra(4'h0, KIND_PERIOD), 16'hFFFF);
    wr_reg(ra(4'h0, KIND_COUNT), 16'h0000);
    wr_reg(ra(4'h0, KIND_CTRL), 16'h8040);
    repeat (20) @(posedge mclk);
    rd_reg(ra(4'h0, KIND_COUNT), v); check("gate low holds", 16'h0000, v);
    ext_clock_pin[0] <= 1'b1;
    repeat (20) @(posedge mclk);
    ext_clock_pin[0] <= 1'b0;
    repeat (8) @(posedge mclk);
    rd_reg(ra(4'h0, KIND_COUNT), v); check_range("gate high counts", 16'h000F, 16'h0018, v);
    check("gate fall flag", 16'h0001, {7'h00, irq_flag} & 16'h0001);
    wr_reg(ra(4'h1, KIND_COUNT), 16'h0000);
    idle_mode <= 1'b1;
    wr_reg(ra(4'h1, KIND_CTRL), 16'hA000);
    repeat (20) @(posedge mclk);
    rd_reg(ra(4'h1, KIND_COUNT), v); check("idle halts", 16'h0000, v);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h8000);
    repeat (20) @(posedge mclk);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h0000);
    idle_mode <= 1'b0;
    rd_reg(ra(4'h1, KIND_COUNT), v); check_range("idle runs", 16'h0012, 16'h0018, v);
    wr_reg(ra(4'h3, KIND_COUNT), 16'h0000);
    wr_reg(ra(4'h3, KIND_CTRL), 16'h8042);
    pin_pulses(3, 10);
    repeat (6) @(posedge mclk);
    rd_reg(ra(4'h3, KIND_COUNT), v); check("pin edges counted", 16'h000A, v);
    sleep_mode <= 1'b1;
    pin_pulses(3, 3);
    repeat (6) @(posedge mclk);
    rd_reg(ra(4'h3, KIND_COUNT), v); check("pair stops in sleep", 16'h000A, v);
    wr_reg(ra(4'h3, KIND_CTRL), 16'h0000);
    wr_reg(ra(4'h0, KIND_COUNT), 16'h0000);
    wr_reg(ra(4'h0, KIND_CTRL), 16'h8002);
    pin_pulses(0, 5);
    repeat (6) @(posedge mclk);
    rd_reg(ra(4'h0, KIND_COUNT), v); check("async in sleep", 16'h0005, v);
    wr_reg(ra(4'h0, KIND_CTRL), 16'h0000);
    sleep_mode <= 1'b0;
    // The high timer is left stopped so that only the low timer's run bit can drive the pair.
    wr_reg(ra(4'h1, KIND_COUNT), 16'hFFF8);
    wr_reg(ra(4'h2, KIND_COUNT), 16'h0000);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h0008);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h8008);
    repeat (20) @(posedge mclk);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h0008);
    rd_reg(ra(4'h2, KIND_COUNT), v); check("carry to high word", 16'h0001, v);
    wr_reg(ra(4'h2, KIND_PERIOD), 16'h0001);
    wr_reg(ra(4'h1, KIND_PERIOD), 16'h0002);
    wr_reg(ra(4'h1, KIND_COUNT), 16'hFFF0);
    wr_reg(ra(4'h2, KIND_COUNT), 16'h0000);
    wr_reg(FLAG_ADDR, 16'h01FF);
    adc1_seen = 0;
    adc2_seen = 0;
    dma_seen = 0;
    wr_reg(ra(4'h1, KIND_CTRL), 16'h8008);
    repeat (40) @(posedge mclk);
    wr_reg(ra(4'h1, KIND_CTRL), 16'h0008);
    check("joined flag on high", 16'h0004, {7'h00, irq_flag} & 16'h0006);
    check("adc1 trigger", 16'h0001, 16'(adc1_seen));
    check("adc2 silent", 16'h0000, 16'(adc2_seen));
    check("dma request", 16'h0001, 16'(dma_seen));
    rd_reg(ra(4'h1, KIND_COUNT), v); check("time base low", v, time_base_low);
    rd_reg(ra(4'h2, KIND_COUNT), v); check("time base high", v, time_base_high);
    check("high word cleared", 16'h0000, v);
    tally_and_finish();
  end
endmodule // test_general_timer_set
